// >>> tpio_consts.svh
// Constants for the timing pulse I/O unit: clock rate, times, ids, resets
`ifndef TPIO_CONSTS_SVH
`define TPIO_CONSTS_SVH

`define TPIO_CLK_HZ          100000000
`define TPIO_SEC_S           1
`define TPIO_PPS_LOW_US      1000
`define TPIO_PPS_HIGH_US     999000
`define TPIO_IMU_LO_HZ       100
`define TPIO_IMU_HI_HZ       250
`define TPIO_EVT_LO_HZ       1
`define TPIO_EVT_HI_HZ       4
`define TPIO_EVT_EDGE_HZ     50
`define TPIO_CAM_PULSE_US    10

`define TPIO_SEC_CYC         (`TPIO_SEC_S * `TPIO_CLK_HZ)
`define TPIO_PPS_LOW_CYC     (`TPIO_PPS_LOW_US * (`TPIO_CLK_HZ / 1000000))
`define TPIO_IMU_LO_CYC      (`TPIO_CLK_HZ / `TPIO_IMU_LO_HZ)
`define TPIO_IMU_HI_CYC      (`TPIO_CLK_HZ / `TPIO_IMU_HI_HZ)
`define TPIO_EVT_LO_CYC      (`TPIO_CLK_HZ / `TPIO_EVT_LO_HZ)
`define TPIO_EVT_HI_CYC      (`TPIO_CLK_HZ / `TPIO_EVT_HI_HZ)
`define TPIO_EVT_EDGE_CYC    (`TPIO_CLK_HZ / `TPIO_EVT_EDGE_HZ)
`define TPIO_CAM_PULSE_CYC   (`TPIO_CAM_PULSE_US * (`TPIO_CLK_HZ / 1000000))

`define TPIO_MSG_ID_A        8'h18
`define TPIO_MSG_ID_B        8'h2B

`define TPIO_PPS_RST         1'b1
`define TPIO_SYNC_RST        1'b1
`define TPIO_CAM_RST         1'b0

`endif

// >>> tpio_pkg.sv
// Types shared by the timing pulse I/O unit
package tpio_pkg;

	typedef struct packed {
		logic [31:0] sec;
		logic [31:0] sub;
	} tpio_stamp_t;

	typedef struct packed {
		logic        valid;
		logic [7:0]  msg_id;
		logic        rising;
		tpio_stamp_t stamp;
	} tpio_evt_rpt_t;

	typedef struct packed {
		logic rise_en;
		logic fall_en;
	} tpio_evt_cfg_t;

	typedef struct packed {
		logic [15:0] dist_m;
		logic [15:0] pulses_per_m;
	} tpio_cam_cfg_t;

	typedef enum logic [2:0] {
		TPIO_RPT_IDLE = 3'b001,
		TPIO_RPT_A    = 3'b010,
		TPIO_RPT_B    = 3'b100
	} tpio_rpt_state_t;

	typedef enum logic [1:0] {
		TPIO_CAM_IDLE  = 2'b01,
		TPIO_CAM_PULSE = 2'b10
	} tpio_cam_state_t;

endpackage

// >>> tpio_edge.sv
// Two-stage synchroniser with rise and fall detection
`timescale 1ns/1ps
module tpio_edge (
	input  wire logic clk,
	input  wire logic sys_rst,
	input  wire logic din,
	output logic      rise,
	output logic      fall
);
	logic       meta_reg;
	logic       sync_reg;
	logic       prev_reg;
	logic [2:0] fill_reg;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			prev_reg <= 1'b0;
		end else begin
			meta_reg <= din;
			sync_reg <= meta_reg;
			prev_reg <= sync_reg;
		end
	end

	// Edges held off until the chain holds real samples of the pin
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			fill_reg <= 3'h0;
		end else begin
			fill_reg <= {fill_reg[1:0], 1'b1};
		end
	end

	assign rise = fill_reg[2] & sync_reg & ~prev_reg;
	assign fall = fill_reg[2] & ~sync_reg & prev_reg;
endmodule

// >>> tpio_top.sv
// Timing pulse I/O unit: second pulse, sample sync, event stamps, camera
//
// Notes on behaviour
// - Second pulse falls exactly at each satellite-time second boundary.
// - Second pulse low 1 ms after boundary, high 999 ms, every second.
// - Edges on the event input are timestamped for external occurrences.
// - Default event rate limit: 1 Hz on 100 Hz units, 4 Hz on 250 Hz.
// - Selecting rising, falling or both edges raises the limit to 50 Hz.
// - Each captured event is reported tagged as message 24 and message 43.
// - Odometer wheel is taken to travel straight; no steering correction.
// - One camera trigger pulse per fixed distance travelled.
// - Metres between camera triggers is a configuration input.
// - Sync output at 100 Hz or 250 Hz, locked to inertial sample time.
// - Sync output roughly 50% duty, falling edge at each sample.
// - One sync falling edge each second lines up with the second pulse.
`timescale 1ns/1ps
`include "tpio_consts.svh"
module tpio_top
	import tpio_pkg::*;
#(
	parameter int unsigned SEC_CYC      = `TPIO_SEC_CYC,
	parameter int unsigned PPS_LOW_CYC  = `TPIO_PPS_LOW_CYC,
	parameter int unsigned IMU_LO_CYC   = `TPIO_IMU_LO_CYC,
	parameter int unsigned IMU_HI_CYC   = `TPIO_IMU_HI_CYC,
	parameter int unsigned EVT_LO_CYC   = `TPIO_EVT_LO_CYC,
	parameter int unsigned EVT_HI_CYC   = `TPIO_EVT_HI_CYC,
	parameter int unsigned EVT_EDGE_CYC = `TPIO_EVT_EDGE_CYC,
	parameter int unsigned CAM_CYC      = `TPIO_CAM_PULSE_CYC
) (
	input  wire logic    clk,
	input  wire logic    sys_rst,
	input  wire logic    sec_mark,
	input  wire logic    rate_hi,
	input  wire logic    evt_in,
	input  wire tpio_evt_cfg_t evt_cfg,
	input  wire logic    odo_in,
	input  wire tpio_cam_cfg_t cam_cfg,
	output logic         pps_out,
	output logic         imu_sync_out,
	output logic         cam_trig_out,
	output tpio_evt_rpt_t evt_rpt,
	output tpio_stamp_t  odo_stamp,
	output logic [31:0]  odo_count,
	output logic [15:0]  evt_drop_count
);
	if (PPS_LOW_CYC < 1 || PPS_LOW_CYC >= SEC_CYC) begin : g_chk_pps
		$error("second pulse low time must be within one second");
	end
	if (IMU_HI_CYC < 2 || IMU_LO_CYC < 2) begin : g_chk_imu
		$error("sync period too short");
	end
	if (EVT_EDGE_CYC < 3 || EVT_HI_CYC < 3 || EVT_LO_CYC < 3) begin : g_chk_evt
		$error("event spacing must be at least three cycles");
	end
	if (CAM_CYC < 1) begin : g_chk_cam
		$error("camera pulse must be at least one cycle");
	end

	function automatic logic [31:0] inc32(input logic [31:0] v);
		inc32 = v + 32'h1;
	endfunction
	logic            pps_reg;
	logic            sync_reg;
	logic            cam_reg;
	logic [31:0]     sub_reg;
	logic [31:0]     sec_reg;
	logic [31:0]     imu_reg;
	logic [31:0]     hold_reg;
	logic [31:0]     odo_acc_reg;
	logic [31:0]     odo_cnt_reg;
	logic [31:0]     target_reg;
	logic [31:0]     cam_cnt_reg;
	logic [15:0]     drop_reg;
	tpio_stamp_t     odo_stamp_reg;
	tpio_stamp_t     evt_stamp_reg;
	logic            evt_pol_reg;
	tpio_evt_rpt_t   rpt_reg;
	tpio_rpt_state_t rpt_state_reg;
	tpio_cam_state_t cam_state_reg;

	logic        boundary;
	logic [31:0] imu_period;
	logic        imu_wrap;
	logic        ev_rise;
	logic        ev_fall;
	logic        odo_rise;
	logic        ev_hit;
	logic        ev_accept;
	logic [31:0] ev_gap;
	logic        cam_fire;
	tpio_stamp_t now;
	tpio_edge u_evt_edge (
		.clk     (clk),
		.sys_rst (sys_rst),
		.din     (evt_in),
		.rise    (ev_rise),
		.fall    (ev_fall)
	);
	tpio_edge u_odo_edge (
		.clk     (clk),
		.sys_rst (sys_rst),
		.din     (odo_in),
		.rise    (odo_rise),
		.fall    ()
	);
	// Second boundary from the disciplined mark, flywheel if it is missing
	assign boundary = sec_mark || (sub_reg == 32'(SEC_CYC - 1));
	assign now.sec  = sec_reg;
	assign now.sub  = sub_reg;

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sub_reg <= 32'h0;
			sec_reg <= 32'h0;
		end else if (boundary) begin
			sub_reg <= 32'h0;
			sec_reg <= inc32(sec_reg);
		end else begin
			sub_reg <= inc32(sub_reg);
		end
	end

	// Low from the boundary for the low time, high for the rest
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			pps_reg <= `TPIO_PPS_RST;
		end else if (boundary) begin
			pps_reg <= 1'b0;
		end else begin
			pps_reg <= (inc32(sub_reg) >= 32'(PPS_LOW_CYC));
		end
	end

	// Sample sync: phase restarted on each second boundary
	assign imu_period = rate_hi ? 32'(IMU_HI_CYC) : 32'(IMU_LO_CYC);
	assign imu_wrap   = boundary || (imu_reg >= imu_period - 32'h1);

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			imu_reg <= 32'h0;
		end else if (imu_wrap) begin
			imu_reg <= 32'h0;
		end else begin
			imu_reg <= inc32(imu_reg);
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync_reg <= `TPIO_SYNC_RST;
		end else if (imu_wrap) begin
			sync_reg <= 1'b0;
		end else begin
			sync_reg <= (inc32(imu_reg) >= (imu_period >> 1));
		end
	end

	// Event edge choice and rate limit
	always_comb begin
		if (evt_cfg.rise_en || evt_cfg.fall_en) begin
			ev_hit = (evt_cfg.rise_en && ev_rise)
				|| (evt_cfg.fall_en && ev_fall);
			ev_gap = 32'(EVT_EDGE_CYC);
		end else begin
			ev_hit = ev_fall;
			ev_gap = rate_hi ? 32'(EVT_HI_CYC) : 32'(EVT_LO_CYC);
		end
	end
	assign ev_accept = ev_hit && (hold_reg == 32'h0);
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hold_reg <= 32'h0;
		end else if (ev_accept) begin
			hold_reg <= ev_gap - 32'h1;
		end else if (hold_reg != 32'h0) begin
			hold_reg <= hold_reg - 32'h1;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			drop_reg <= 16'h0000;
		end else if (ev_hit && !ev_accept && drop_reg != 16'hFFFF) begin
			drop_reg <= drop_reg + 16'h0001;
		end
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			evt_stamp_reg <= '0;
			evt_pol_reg   <= 1'b0;
		end else if (ev_accept) begin
			evt_stamp_reg <= now;
			evt_pol_reg   <= ev_rise;
		end
	end

	// Report each capture twice, one per status message
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			rpt_state_reg <= TPIO_RPT_IDLE;
			rpt_reg       <= '0;
		end else begin
			case (rpt_state_reg)
				TPIO_RPT_IDLE: begin
					rpt_reg.valid <= 1'b0;
					if (ev_accept) begin
						rpt_state_reg <= TPIO_RPT_A;
					end
				end
				TPIO_RPT_A: begin
					rpt_reg.valid  <= 1'b1;
					rpt_reg.msg_id <= `TPIO_MSG_ID_A;
					rpt_reg.rising <= evt_pol_reg;
					rpt_reg.stamp  <= evt_stamp_reg;
					rpt_state_reg  <= TPIO_RPT_B;
				end
				TPIO_RPT_B: begin
					rpt_reg.valid  <= 1'b1;
					rpt_reg.msg_id <= `TPIO_MSG_ID_B;
					rpt_state_reg  <= TPIO_RPT_IDLE;
				end
				default: begin
					rpt_reg.valid <= 1'b0;
					rpt_state_reg <= TPIO_RPT_IDLE;
				end
			endcase
		end
	end

	// Odometer: wheel pulses counted as straight-line distance
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			target_reg <= 32'h0;
		end else begin
			target_reg <= 32'(cam_cfg.dist_m)
				* 32'(cam_cfg.pulses_per_m);
		end
	end

	assign cam_fire = odo_rise && (target_reg != 32'h0)
		&& (inc32(odo_acc_reg) >= target_reg);
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			odo_acc_reg   <= 32'h0;
			odo_cnt_reg   <= 32'h0;
			odo_stamp_reg <= '0;
		end else if (odo_rise) begin
			odo_acc_reg   <= cam_fire ? 32'h0 : inc32(odo_acc_reg);
			odo_cnt_reg   <= inc32(odo_cnt_reg);
			odo_stamp_reg <= now;
		end
	end

	// Camera pulse; a new trigger during a pulse restarts its width
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			cam_state_reg <= TPIO_CAM_IDLE;
			cam_cnt_reg   <= 32'h0;
			cam_reg       <= `TPIO_CAM_RST;
		end else begin
			case (cam_state_reg)
				TPIO_CAM_IDLE: begin
					if (cam_fire) begin
						cam_state_reg <= TPIO_CAM_PULSE;
						cam_cnt_reg   <= 32'(CAM_CYC - 1);
						cam_reg       <= 1'b1;
					end
				end
				TPIO_CAM_PULSE: begin
					if (cam_fire) begin
						cam_cnt_reg <= 32'(CAM_CYC - 1);
					end else if (cam_cnt_reg == 32'h0) begin
						cam_state_reg <= TPIO_CAM_IDLE;
						cam_reg       <= 1'b0;
					end else begin
						cam_cnt_reg <= cam_cnt_reg - 32'h1;
					end
				end
				default: begin
					cam_state_reg <= TPIO_CAM_IDLE;
					cam_reg       <= 1'b0;
				end
			endcase
		end
	end
	assign pps_out        = pps_reg;
	assign imu_sync_out   = sync_reg;
	assign cam_trig_out   = cam_reg;
	assign evt_rpt        = rpt_reg;
	assign odo_stamp      = odo_stamp_reg;
	assign odo_count      = odo_cnt_reg;
	assign evt_drop_count = drop_reg;
endmodule

// >>> tpio_assertions.sv
// Port checker for the timing pulse I/O unit
`timescale 1ns/1ps
module tpio_chk
	import tpio_pkg::*;
#(
	parameter int unsigned PPS_LOW_CYC = 20,
	parameter int unsigned CAM_CYC     = 4
) (
	input wire logic          clk,
	input wire logic          sys_rst,
	input wire logic          sec_mark,
	input wire logic          pps_out,
	input wire logic          imu_sync_out,
	input wire logic          cam_trig_out,
	input wire tpio_evt_rpt_t evt_rpt,
	input wire logic [31:0]   odo_count,
	input wire logic [15:0]   evt_drop_count
);
	logic [31:0] lo_reg;
	logic [31:0] hi_reg;
	logic        arm_reg;
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	// Low run of the second pulse, armed by a real boundary
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			lo_reg <= 32'h0;
			arm_reg <= 1'b0;
		end else begin
			lo_reg <= (sec_mark || pps_out) ? 32'h0 : lo_reg + 32'h1;
			arm_reg <= arm_reg | sec_mark;
		end
	end
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			hi_reg <= 32'h0;
		end else begin
			hi_reg <= cam_trig_out ? hi_reg + 32'h1 : 32'h0;
		end
	end
	property p_pps_edge;
		sec_mark |=> !pps_out;
	endproperty
	a_pps_edge: assert property (p_pps_edge)
		else $error("second pulse did not fall at boundary");
	property p_sync_edge;
		sec_mark |=> !imu_sync_out;
	endproperty
	a_sync_edge: assert property (p_sync_edge)
		else $error("sync did not fall with second pulse");
	property p_pps_low;
		$rose(pps_out) && arm_reg |-> lo_reg == PPS_LOW_CYC;
	endproperty
	a_pps_low: assert property (p_pps_low)
		else $error("second pulse low time wrong");
	property p_evt_pair;
		$rose(evt_rpt.valid) |-> evt_rpt.msg_id == 8'h18 ##1
			(evt_rpt.valid && evt_rpt.msg_id == 8'h2B) ##1 !evt_rpt.valid;
	endproperty
	a_evt_pair: assert property (p_evt_pair)
		else $error("event report words wrong");
	property p_evt_stamp;
		evt_rpt.valid && $past(evt_rpt.valid) |-> $stable(evt_rpt.stamp);
	endproperty
	a_evt_stamp: assert property (p_evt_stamp)
		else $error("event stamp changed inside report");
	property p_drop_step;
		$changed(evt_drop_count) |->
			evt_drop_count == $past(evt_drop_count) + 16'h1;
	endproperty
	a_drop_step: assert property (p_drop_step)
		else $error("drop count stepped wrongly");
	property p_cam_rise;
		$rose(cam_trig_out) |-> odo_count != $past(odo_count);
	endproperty
	a_cam_rise: assert property (p_cam_rise)
		else $error("camera trigger without odometer pulse");
	property p_cam_width;
		$fell(cam_trig_out) |-> hi_reg == CAM_CYC;
	endproperty
	a_cam_width: assert property (p_cam_width)
		else $error("camera pulse width wrong");
	c_evt: cover property ($rose(evt_rpt.valid));
	c_cam: cover property ($rose(cam_trig_out));
	c_drop: cover property ($changed(evt_drop_count));
endmodule

bind tpio_top tpio_chk #(
	.PPS_LOW_CYC(PPS_LOW_CYC),
	.CAM_CYC    (CAM_CYC)
) u_chk (
	.clk           (clk),
	.sys_rst       (sys_rst),
	.sec_mark      (sec_mark),
	.pps_out       (pps_out),
	.imu_sync_out  (imu_sync_out),
	.cam_trig_out  (cam_trig_out),
	.evt_rpt       (evt_rpt),
	.odo_count     (odo_count),
	.evt_drop_count(evt_drop_count)
);

// >>> tpio_far.sv
// Far-side model: event switch with pull-up and wheel encoder
`timescale 1ns/1ps
module tpio_far (
	input  wire logic       clk,
	input  wire logic       evt_req,
	input  wire logic       odo_req,
	input  wire logic [3:0] hold,
	output logic            evt_in,
	output logic            odo_in
);
	logic [3:0] evt_cnt_reg = 4'h0;
	logic [3:0] odo_cnt_reg = 4'h0;
	always_ff @(posedge clk) begin
		evt_cnt_reg <= evt_req ? hold : evt_cnt_reg - {3'h0, evt_cnt_reg != 4'h0};
		odo_cnt_reg <= odo_req ? hold : odo_cnt_reg - {3'h0, odo_cnt_reg != 4'h0};
	end
	// Closed switch pulls low, released line returns high
	assign evt_in = (evt_cnt_reg == 4'h0);
	// Single non-steering wheel encoder, no added delay
	assign odo_in = (odo_cnt_reg != 4'h0);
endmodule

// >>> tpio_top_tb_top.sv
// Self-checking bench for the timing pulse I/O unit
`timescale 1ns/1ps
module tpio_top_tb_top import tpio_pkg::*;;
	localparam int unsigned SEC = 2000;
	localparam int unsigned LOW = 20;
	localparam int unsigned PLO = 200;
	localparam int unsigned PHI = 80;
	localparam int unsigned ELO = 400;
	localparam int unsigned EHI = 100;
	localparam int unsigned EED = 8;
	logic          clk = 1'b0, sys_rst = 1'b1, sec_mark = 1'b0;
	logic          rate_hi = 1'b0, evt_req = 1'b0, odo_req = 1'b0;
	logic [3:0]    hold = 4'h3;
	logic          evt_in, odo_in, pps_out, imu_sync_out, cam_trig_out;
	logic          last_rise;
	tpio_evt_cfg_t evt_cfg = '0;
	tpio_cam_cfg_t cam_cfg = '0;
	tpio_evt_rpt_t evt_rpt;
	tpio_stamp_t   odo_stamp;
	logic [31:0]   odo_count;
	logic [15:0]   evt_drop_count;
	logic [63:0]   t_a, t_b;
	int            miscompares = 0, checks_done = 0, nrep = 0, ncam = 0;
	always #5 clk = ~clk;
	function automatic logic [63:0] stamp_of(input tpio_stamp_t s);
		return 64'(s.sec) * SEC + 64'(s.sub);
	endfunction
	tpio_top #(.SEC_CYC(SEC), .PPS_LOW_CYC(LOW), .IMU_LO_CYC(PLO),
		.IMU_HI_CYC(PHI), .EVT_LO_CYC(ELO), .EVT_HI_CYC(EHI),
		.EVT_EDGE_CYC(EED), .CAM_CYC(4)) u_dut (.clk(clk),
		.sys_rst(sys_rst), .sec_mark(sec_mark), .rate_hi(rate_hi),
		.evt_in(evt_in), .evt_cfg(evt_cfg), .odo_in(odo_in),
		.cam_cfg(cam_cfg), .pps_out(pps_out), .imu_sync_out(imu_sync_out),
		.cam_trig_out(cam_trig_out), .evt_rpt(evt_rpt),
		.odo_stamp(odo_stamp), .odo_count(odo_count),
		.evt_drop_count(evt_drop_count));
	tpio_far u_far (.clk(clk), .evt_req(evt_req), .odo_req(odo_req),
		.hold(hold), .evt_in(evt_in), .odo_in(odo_in));
	always @(posedge clk) begin
		if (evt_rpt.valid && evt_rpt.msg_id == 8'h18) begin
			nrep++;
			last_rise = evt_rpt.rising;
			t_a = t_b;
			t_b = stamp_of(evt_rpt.stamp);
		end
		if ($rose(cam_trig_out)) ncam++;
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("wrong value at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic req(input logic odo);
		evt_req <= !odo;
		odo_req <= odo;
		@(posedge clk);
		evt_req <= 1'b0;
		odo_req <= 1'b0;
	endtask
	function automatic int gap_of(input tpio_evt_cfg_t c, input logic r);
		return (c.rise_en || c.fall_en) ? EED : (r ? EHI : ELO);
	endfunction
	function automatic logic exp_sync(input int k, input logic r);
		return ((k % SEC) % (r ? PHI : PLO)) >= (r ? PHI : PLO) / 2;
	endfunction
	initial begin
		int            g, w, e0, n0, n, d, p;
		logic [31:0]   o0;
		logic [63:0]   s0;
		logic [15:0]   d0;
		tpio_evt_cfg_t c;
		void'($urandom(32'hC51A));
		cyc(3);
		sys_rst <= 1'b0;
		cyc(40);
		for (int i = 0; i < 2; i++) begin
			rate_hi <= i[0];
			sec_mark <= 1'b1;
			@(posedge clk);
			sec_mark <= 1'b0;
			for (int k = 0; k < SEC + 50; k++) begin
				@(negedge clk);
				chk(pps_out, (k % SEC) >= LOW);
				chk(imu_sync_out, exp_sync(k, i[0]));
				@(posedge clk);
			end
		end
		for (int i = 0; i < 16; i++) begin
			c = tpio_evt_cfg_t'(i[1:0]);
			evt_cfg <= c;
			rate_hi <= i[2];
			g = gap_of(c, i[2]);
			w = i[3] ? g + 10 + int'($urandom % 20) : g / 2;
			e0 = nrep;
			d0 = evt_drop_count;
			cyc(2);
			req(1'b0);
			cyc(w - 1);
			req(1'b0);
			cyc(ELO + 30);
			chk(nrep - e0, 1 + (w >= g));
			chk(evt_drop_count - d0, (c == 2'b11 ? 3 : 1) - (w >= g));
			if (w >= g) chk(t_b - t_a, w);
			chk(last_rise, c == 2'b10);
		end
		for (int i = 0; i < 4; i++) begin
			d = (i == 3) ? 0 : 1 + int'($urandom % 3);
			p = 1 + int'($urandom % 3);
			n = (i == 3) ? 5 : 2 * d * p;
			cam_cfg <= {16'(d), 16'(p)};
			hold <= 4'(2 + $urandom % 4);
			o0 = odo_count;
			n0 = ncam;
			cyc(2);
			for (int j = 0; j < n; j++) begin
				req(1'b1);
				cyc(11);
				if (j == 0) s0 = stamp_of(odo_stamp);
			end
			cyc(20);
			chk(odo_count - o0, n);
			chk(ncam - n0, (i == 3) ? 0 : 2);
			chk(stamp_of(odo_stamp) - s0, 12 * (n - 1));
		end
		final_report();
	end
	initial begin
		#400000;
		miscompares++;
		final_report();
	end
endmodule
